// ==== rtl/ddrs_top.v ====
`include "ddrs_consts.vh"

module ddrs_top (
    input wire clk_sys,
    input wire resetn,
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output wire avs_waitrequest,
    output reg [31:0] avs_readdata,
    output wire irq,
    output wire move_step,
    output wire move_ccw,
    output wire move_busy,
    output wire home_valid,
    output wire multi_rev_excess_warning
);

    // ----------------------------------------------------------------
    // State encodings
    // ----------------------------------------------------------------
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_MOVE = 2'b10;

    // Merges a write into a word under the byte enables.
    function [31:0] be_merge;
        input [31:0] old;
        input [31:0] wd;
        input [3:0] be;
        begin
            be_merge = {be[3] ? wd[31:24] : old[31:24], be[2] ? wd[23:16] : old[23:16],
                        be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
        end
    endfunction

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    // Every access takes one wait state: the answer is formed at the first
    // edge and completes at the second, keeping decode off the data path.
    reg ack_q;
    wire acc;
    wire wr_fire;

    assign acc = avs_read | avs_write;
    assign avs_waitrequest = acc & ~ack_q;
    assign wr_fire = avs_write & ack_q;

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= acc & ~ack_q;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    reg [31:0] ctrl_q;
    reg [31:0] target_q;
    reg [31:0] home_pos_q;
    reg home_valid_q;
    reg [31:0] cur_pos_q;
    reg [31:0] cur_pos_d;
    reg [17:0] rev_q;
    reg [17:0] rev_d;
    reg warn_q;
    reg [`DDRS_IRQ_WIDTH-1:0] irq_sts_q;
    reg [`DDRS_IRQ_WIDTH-1:0] irq_mask_q;
    reg [1:0] state_q;
    reg [1:0] sel_q;
    reg ccw_q;
    reg [31:0] remain_q;

    wire [1:0] dir_sel;
    wire cwe;
    wire [1:0] unit;
    wire unit_deg;

    assign dir_sel = ctrl_q[`DDRS_CTRL_SEL_LO+1:`DDRS_CTRL_SEL_LO];
    assign cwe = ctrl_q[`DDRS_CTRL_CWE_BIT];
    assign unit = ctrl_q[`DDRS_CTRL_UNIT_LO+1:`DDRS_CTRL_UNIT_LO];
    assign unit_deg = (unit == `DDRS_UNIT_DEGREE);

    wire wr_ctrl;
    wire wr_target;
    wire wr_cmd;
    wire wr_home;
    wire wr_irq_sts;
    wire wr_irq_mask;

    assign wr_ctrl = wr_fire & (avs_address == `DDRS_ADDR_CTRL);
    assign wr_target = wr_fire & (avs_address == `DDRS_ADDR_TARGET);
    assign wr_cmd = wr_fire & (avs_address == `DDRS_ADDR_CMD) & avs_byteenable[0];
    assign wr_home = wr_fire & (avs_address == `DDRS_ADDR_HOME_POS);
    assign wr_irq_sts = wr_fire & (avs_address == `DDRS_ADDR_IRQ_STS) & avs_byteenable[0];
    assign wr_irq_mask = wr_fire & (avs_address == `DDRS_ADDR_IRQ_MASK) & avs_byteenable[0];

    // ----------------------------------------------------------------
    // Move start and direction choice
    // ----------------------------------------------------------------
    wire start_abs;
    wire start_rel;
    wire start;
    wire calc_ccw;
    wire [31:0] calc_dist;

    assign start_abs = wr_cmd & avs_writedata[`DDRS_CMD_ABS_BIT];
    assign start_rel = wr_cmd & avs_writedata[`DDRS_CMD_REL_BIT] & ~avs_writedata[`DDRS_CMD_ABS_BIT];
    // A start command while a move runs is ignored.
    assign start = (start_abs | start_rel) & (state_q == ST_IDLE);

    ddrs_dir_calc u_dir (
        .dir_sel(dir_sel),
        .is_abs(start_abs),
        .target(target_q),
        .cur_pos(cur_pos_q),
        .move_ccw(calc_ccw),
        .move_dist(calc_dist)
    );

    wire stepping;
    wire done_ev;

    assign stepping = (state_q == ST_MOVE) & (remain_q != 32'h0);
    assign done_ev = ((state_q == ST_MOVE) & (remain_q == 32'h1)) | (start & (calc_dist == 32'h0));

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_q <= ST_IDLE;
            sel_q <= `DDRS_SEL_SIGN;
            ccw_q <= 1'b1;
            remain_q <= 32'h0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (start) begin
                        state_q <= (calc_dist != 32'h0) ? ST_MOVE : ST_IDLE;
                        sel_q <= dir_sel;
                        ccw_q <= calc_ccw;
                        remain_q <= calc_dist;
                    end
                end
                ST_MOVE: begin
                    if (remain_q <= 32'h1) begin
                        state_q <= ST_IDLE;
                        remain_q <= 32'h0;
                    end else begin
                        remain_q <= remain_q - 32'h1;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    remain_q <= 32'h0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Position and revolution tracking
    // ----------------------------------------------------------------
    wire wrap_ccw;
    wire wrap_cw;
    wire rev_over;

    assign wrap_ccw = stepping & ccw_q & (cur_pos_q == `DDRS_POS_MAX);
    assign wrap_cw = stepping & ~ccw_q & (cur_pos_q == 32'h0);
    assign rev_over = (~rev_q[17] & (rev_q >= `DDRS_REV_LIMIT)) | (rev_q[17] & (rev_q <= `DDRS_REV_LIMIT_NEG));

    always @* begin
        cur_pos_d = cur_pos_q;
        if (stepping) begin
            if (ccw_q) begin
                cur_pos_d = wrap_ccw ? 32'h0 : cur_pos_q + 32'h1;
            end else begin
                cur_pos_d = wrap_cw ? `DDRS_POS_MAX : cur_pos_q - 32'h1;
            end
        end
    end

    // The counter saturates at the limit so a long run cannot wrap it back
    // into range and hide the excess condition.
    always @* begin
        rev_d = rev_q;
        if (wr_home) begin
            rev_d = 18'h0;
        end else if (wrap_ccw && !(~rev_q[17] && rev_q >= `DDRS_REV_LIMIT)) begin
            rev_d = rev_q + 18'h1;
        end else if (wrap_cw && !(rev_q[17] && rev_q <= `DDRS_REV_LIMIT_NEG)) begin
            rev_d = rev_q - 18'h1;
        end
    end

    wire warn_set;

    // Degree unit is infinite feed: the modulo position is the whole truth.
    // A home write zeroes the counter, so the excess condition ends in that cycle.
    assign warn_set = rev_over & cwe & ~unit_deg & ~warn_q & ~wr_home;

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cur_pos_q <= 32'h0;
            rev_q <= 18'h0;
            warn_q <= 1'b0;
            home_pos_q <= 32'h0;
            home_valid_q <= 1'b0;
        end else begin
            cur_pos_q <= cur_pos_d;
            rev_q <= rev_d;
            if (wr_home) begin
                // Clamp into one turn in millidegrees.
                home_pos_q <= (be_merge(home_pos_q, avs_writedata, avs_byteenable) > `DDRS_POS_MAX) ?
                              `DDRS_POS_MAX : be_merge(home_pos_q, avs_writedata, avs_byteenable);
                home_valid_q <= 1'b1;
                warn_q <= 1'b0;
            end else if (warn_set) begin
                warn_q <= 1'b1;
                home_valid_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= `DDRS_CTRL_RESET;
            target_q <= 32'h0;
            irq_mask_q <= {`DDRS_IRQ_WIDTH{1'b0}};
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= be_merge(ctrl_q, avs_writedata, avs_byteenable) & 32'h0000_001f;
            end
            if (wr_target) begin
                target_q <= be_merge(target_q, avs_writedata, avs_byteenable);
            end
            if (wr_irq_mask) begin
                irq_mask_q <= avs_writedata[`DDRS_IRQ_WIDTH-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    wire [`DDRS_IRQ_WIDTH-1:0] irq_set;
    wire [`DDRS_IRQ_WIDTH-1:0] irq_clr;

    assign irq_set = {warn_set, warn_set, done_ev};
    assign irq_clr = wr_irq_sts ? avs_writedata[`DDRS_IRQ_WIDTH-1:0] : {`DDRS_IRQ_WIDTH{1'b0}};

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            irq_sts_q <= {`DDRS_IRQ_WIDTH{1'b0}};
        end else begin
            // A new event in the clearing cycle is kept.
            irq_sts_q <= (irq_sts_q & ~irq_clr) | irq_set;
        end
    end

    assign irq = |(irq_sts_q & irq_mask_q);

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            avs_readdata <= 32'h0;
        end else if (avs_read && !ack_q) begin
            case (avs_address)
                `DDRS_ADDR_CTRL: avs_readdata <= ctrl_q;
                `DDRS_ADDR_TARGET: avs_readdata <= target_q;
                `DDRS_ADDR_STATUS: begin
                    avs_readdata <= {26'h0, sel_q, warn_q, home_valid_q, ccw_q, state_q == ST_MOVE};
                end
                `DDRS_ADDR_CUR_POS: avs_readdata <= cur_pos_q;
                `DDRS_ADDR_HOME_POS: avs_readdata <= home_pos_q;
                `DDRS_ADDR_IRQ_STS: avs_readdata <= {29'h0, irq_sts_q};
                `DDRS_ADDR_IRQ_MASK: avs_readdata <= {29'h0, irq_mask_q};
                `DDRS_ADDR_REV_CNT: avs_readdata <= {{14{rev_q[17]}}, rev_q};
                default: avs_readdata <= 32'h0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Outputs to the position loop
    // ----------------------------------------------------------------
    assign move_step = stepping;
    assign move_ccw = ccw_q;
    assign move_busy = (state_q == ST_MOVE);
    assign home_valid = home_valid_q;
    assign multi_rev_excess_warning = warn_q;

endmodule // ddrs_top

// ==== shared/ddrs_consts.vh ====
`ifndef DDRS_CONSTS_VH
`define DDRS_CONSTS_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define DDRS_ADDR_CTRL 8'h00
`define DDRS_ADDR_TARGET 8'h04
`define DDRS_ADDR_CMD 8'h08
`define DDRS_ADDR_STATUS 8'h0c
`define DDRS_ADDR_CUR_POS 8'h10
`define DDRS_ADDR_HOME_POS 8'h14
`define DDRS_ADDR_IRQ_STS 8'h18
`define DDRS_ADDR_IRQ_MASK 8'h1c
`define DDRS_ADDR_REV_CNT 8'h20

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define DDRS_CTRL_SEL_LO 0
`define DDRS_CTRL_CWE_BIT 2
`define DDRS_CTRL_UNIT_LO 3
`define DDRS_CTRL_RESET 32'h0000_0004
`define DDRS_CMD_ABS_BIT 0
`define DDRS_CMD_REL_BIT 1
`define DDRS_IRQ_DONE_BIT 0
`define DDRS_IRQ_WARN_BIT 1
`define DDRS_IRQ_HOME_BIT 2
`define DDRS_IRQ_WIDTH 3

// ----------------------------------------------------------------
// Encodings and limits
// ----------------------------------------------------------------
`define DDRS_SEL_SIGN 2'h0
`define DDRS_SEL_SHORT 2'h1
`define DDRS_SEL_DEC 2'h2
`define DDRS_SEL_INC 2'h3
`define DDRS_UNIT_PULSE 2'h0
`define DDRS_UNIT_MM 2'h1
`define DDRS_UNIT_INCH 2'h2
`define DDRS_UNIT_DEGREE 2'h3
`define DDRS_REV_STEPS 32'h0005_7e40
`define DDRS_POS_MAX 32'h0005_7e3f
`define DDRS_REV_LIMIT 18'h0_8000
`define DDRS_REV_LIMIT_NEG 18'h3_8000

`endif

// ==== rtl/ddrs_dir_calc.v ====
`include "ddrs_consts.vh"

module ddrs_dir_calc (
    input wire [1:0] dir_sel,
    input wire is_abs,
    input wire [31:0] target,
    input wire [31:0] cur_pos,
    output reg move_ccw,
    output reg [31:0] move_dist
);

    // Folds a value in -360000..719999 into one turn.
    function [31:0] wrap_deg;
        input [31:0] v;
        begin
            if (v[31]) begin
                wrap_deg = v + `DDRS_REV_STEPS;
            end else if (v >= `DDRS_REV_STEPS) begin
                wrap_deg = v - `DDRS_REV_STEPS;
            end else begin
                wrap_deg = v;
            end
        end
    endfunction

    wire [31:0] tgt_m;
    wire [31:0] ccw_d;
    wire [31:0] cw_d;

    assign tgt_m = wrap_deg(target);
    assign ccw_d = wrap_deg(tgt_m - cur_pos);
    assign cw_d = wrap_deg(cur_pos - tgt_m);

    always @* begin
        move_ccw = 1'b1;
        move_dist = 32'h0;
        if (!is_abs) begin
            move_ccw = ~target[31];
            move_dist = target[31] ? (32'h0 - target) : target;
        end else begin
            case (dir_sel)
                `DDRS_SEL_SIGN: begin
                    // Zero and +360 are non-negative, so they go counter-clockwise.
                    move_ccw = ~target[31];
                    move_dist = target[31] ? cw_d : ccw_d;
                end
                `DDRS_SEL_SHORT: begin
                    move_ccw = (ccw_d <= cw_d);
                    move_dist = (ccw_d <= cw_d) ? ccw_d : cw_d;
                end
                `DDRS_SEL_DEC: begin
                    move_ccw = 1'b0;
                    move_dist = cw_d;
                end
                default: begin
                    move_ccw = 1'b1;
                    move_dist = ccw_d;
                end
            endcase
        end
    end

endmodule // ddrs_dir_calc

// ==== verif/ddrs_top_asserts.sv ====
`include "ddrs_consts.vh"

module ddrs_top_asserts (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic avs_waitrequest,
    input wire logic [31:0] avs_readdata,
    input wire logic irq,
    input wire logic move_step,
    input wire logic move_ccw,
    input wire logic move_busy,
    input wire logic home_valid,
    input wire logic multi_rev_excess_warning
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // Checks seen from the pins only
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    // A move may only begin on the edge that completes a command write.
    wire cmd_done = avs_write && !avs_waitrequest && (avs_address == `DDRS_ADDR_CMD);

    property p_one_wait;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("bus request kept waiting");

    property p_idle_free;
        !(avs_read || avs_write) |-> !avs_waitrequest;
    endproperty
    a_idle_free: assert property (p_idle_free) else $error("wait raised without request");

    property p_start_cause;
        $rose(move_busy) |-> $past(cmd_done);
    endproperty
    a_start_cause: assert property (p_start_cause) else $error("move began without command");

    property p_step_start;
        $rose(move_busy) |-> move_step;
    endproperty
    a_step_start: assert property (p_step_start) else $error("move began without a step");

    property p_ccw_hold;
        move_busy && $past(move_busy) |-> $stable(move_ccw);
    endproperty
    a_ccw_hold: assert property (p_ccw_hold) else $error("direction changed during move");

    property p_ccw_cause;
        $changed(move_ccw) |-> $past(cmd_done);
    endproperty
    a_ccw_cause: assert property (p_ccw_cause) else $error("direction changed between moves");

    property p_home_erase;
        $fell(home_valid) |-> multi_rev_excess_warning;
    endproperty
    a_home_erase: assert property (p_home_erase) else $error("home lost without warning");

    property p_warn_home;
        $rose(multi_rev_excess_warning) |-> ##[0:2] !home_valid;
    endproperty
    a_warn_home: assert property (p_warn_home) else $error("home kept after warning");
endmodule // ddrs_top_asserts

// ==== verif/ddrs_motor_model.sv ====
`include "ddrs_consts.vh"

module ddrs_motor_model (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic move_step,
    input wire logic move_ccw,
    output logic [31:0] pos_q
);
    timeunit 1ns;
    timeprecision 1ps;
    // The motor keeps its own angle so that a wrong step count or direction shows up.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pos_q <= 32'h0;
        end else if (move_step) begin
            if (move_ccw) begin
                pos_q <= (pos_q == `DDRS_POS_MAX) ? 32'h0 : pos_q + 32'h1;
            end else begin
                pos_q <= (pos_q == 32'h0) ? `DDRS_POS_MAX : pos_q - 32'h1;
            end
        end
    end
endmodule // ddrs_motor_model

// ==== verif/ddrs_top_tb.sv ====
`include "ddrs_consts.vh"

module ddrs_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    wire avs_waitrequest;
    wire [31:0] avs_readdata;
    wire irq;
    wire move_step;
    wire move_ccw;
    wire move_busy;
    wire home_valid;
    wire multi_rev_excess_warning;
    wire [31:0] model_pos;
    logic [31:0] rd;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;

    ddrs_top u_dut (.clk_sys(clk_sys), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata), .irq(irq), .move_step(move_step),
        .move_ccw(move_ccw), .move_busy(move_busy), .home_valid(home_valid),
        .multi_rev_excess_warning(multi_rev_excess_warning));
    ddrs_motor_model u_motor (.clk_sys(clk_sys), .resetn(resetn), .move_step(move_step),
        .move_ccw(move_ccw), .pos_q(model_pos));

    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            summarize();
        end
    end

    // ----------------------------------------------------------------
    // Bus and check tasks
    // ----------------------------------------------------------------
    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // The request is held until waitrequest is seen low; one idle edge follows so
    // that a request is never released and raised again in the same step.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic start(input logic [1:0] sel, input logic [31:0] cmd, input logic [31:0] tgt);
        bus(1'b1, `DDRS_ADDR_CTRL, {27'h0, 2'h3, 1'b1, sel});
        bus(1'b1, `DDRS_ADDR_TARGET, tgt);
        bus(1'b1, `DDRS_ADDR_CMD, cmd);
    endtask

    task automatic fin(input logic ccw, input logic [31:0] pos);
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 400) begin
            @(posedge clk_sys);
            n++;
        end
        chk(32'(irq), 32'h1);
        chk(32'(move_ccw), 32'(ccw));
        chk(model_pos, pos);
        rc(`DDRS_ADDR_CUR_POS, pos);
        bus(1'b1, `DDRS_ADDR_IRQ_STS, 32'h1);
        chk(32'(irq), 32'h0);
    endtask

    task automatic mv(input logic [1:0] sel, input logic [31:0] cmd, input logic [31:0] tgt,
            input logic ccw, input logic [31:0] pos);
        start(sel, cmd, tgt);
        fin(ccw, pos);
    endtask

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        rc(`DDRS_ADDR_CTRL, `DDRS_CTRL_RESET);
        rc(`DDRS_ADDR_IRQ_MASK, 32'h0);
        rc(`DDRS_ADDR_CUR_POS, 32'h0);
        bus(1'b1, 8'h24, 32'hffff_ffff);
        rc(8'h24, 32'h0);
        bus(1'b1, `DDRS_ADDR_HOME_POS, 32'h0006_1a80);
        rc(`DDRS_ADDR_HOME_POS, `DDRS_POS_MAX);
        chk(32'(home_valid), 32'h1);
        $display("register test done");
        start(2'h0, 32'h1, 32'h0);
        rc(`DDRS_ADDR_IRQ_STS, 32'h1);
        chk(32'(irq), 32'h0);
        bus(1'b1, `DDRS_ADDR_IRQ_MASK, 32'h1);
        fin(1'b1, 32'h0);
        mv(2'h0, 32'h1, 32'h64, 1'b1, 32'h64);
        mv(2'h0, 32'h1, 32'hfffa_81f2, 1'b0, 32'h32);
        mv(2'h0, 32'h1, 32'hfffa_81c0, 1'b0, 32'h0);
        mv(2'h0, 32'h1, 32'h0005_7e40, 1'b1, 32'h0);
        mv(2'h1, 32'h1, 32'hfffa_8224, 1'b1, 32'h64);
        mv(2'h2, 32'h1, 32'h28, 1'b0, 32'h28);
        mv(2'h2, 32'h1, 32'hfffa_81d4, 1'b0, 32'h14);
        mv(2'h3, 32'h1, 32'hfffa_81de, 1'b1, 32'h1e);
        mv(2'h3, 32'h1, 32'h23, 1'b1, 32'h23);
        mv(2'h2, 32'h2, 32'ha, 1'b1, 32'h2d);
        mv(2'h3, 32'h2, 32'hffff_ffce, 1'b0, 32'h0005_7e3b);
        mv(2'h3, 32'h1, 32'h5, 1'b1, 32'h5);
        $display("direction test done");
        start(2'h3, 32'h1, 32'h64);
        bus(1'b1, `DDRS_ADDR_CTRL, {27'h0, 2'h3, 1'b1, 2'h2});
        bus(1'b0, `DDRS_ADDR_STATUS, 32'h0);
        chk(32'(rd[5:4]), 32'h3);
        bus(1'b1, `DDRS_ADDR_CMD, 32'h1);
        fin(1'b1, 32'h64);
        chk(32'(home_valid), 32'h1);
        chk(32'(multi_rev_excess_warning), 32'h0);
        $display("latch test done");
        summarize();
    end
endmodule // ddrs_top_tb

bind ddrs_top ddrs_top_asserts u_chk (.clk_sys(clk_sys), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
    .irq(irq), .move_step(move_step), .move_ccw(move_ccw), .move_busy(move_busy),
    .home_valid(home_valid), .multi_rev_excess_warning(multi_rev_excess_warning));
